/* edoc_ctrl.sv */
// EDO DRAM strobe controller: drives row/column strobes of a 1M x 16 part.
// Assumes the memory pins attach directly; requests come from clk logic.
// Overview of operation
// (RL1) Wait 200 us, then eight refreshes first
// (RL2) Refresh all 1024 rows within period
// (RL3) Early write keeps device outputs off
// (RL4) Late write enable makes read-modify-write
// (RL5) Device latches data at strobe edges
// (RL6) Output enable off before driving write data
// (RL7) Both column strobes fall together
// (RL8) Setup times from first falling strobe
// (RL9) Hold times from last rising strobe
// (RL10) Column precharge counts with both high
// (RL11) Device outputs off after later rise
// (RL12) Read data valid after longest access
// (RL13) Row low at most 100 us paging
// (RL14) No mixed reads and writes per page
// (RL15) Self refresh low time 100 us plus
// (RL16) Refresh right after and before self refresh
// (RL17) Burst users refresh rows around self refresh
// (RL18) Full refresh between self refresh periods
// (RL19) No different operations per byte
// (RL20) No closely skewed byte strobes
// (RL21) One strobe high gives byte access
// (RL22) Write enable high after read strobes
// (RL23) Keep outputs enabled until data valid
// (RL24) Cycle type from OR of strobes
// (RL25) Row fall with column low refreshes
// (RL26) Strobe intervals as rounded-up cycle counts
// (RL27) Interval counter schedules refreshes
`timescale 1ns/100ps
`default_nettype none
`include "edoc_defines.svh"

module edoc_ctrl #(
  parameter int POWERUP_CYC = `EDOC_POWERUP_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Request side
  input wire logic req_valid,
  output logic req_ready,
  input wire edoc_pkg::edoc_req_t req,
  // Read answer
  output logic rsp_valid,
  output logic [15:0] rdata,
  // Self refresh control
  input wire logic sr_req,
  output logic sr_active,
  // Memory pins
  output edoc_pkg::edoc_pins_t pins,
  input wire logic [15:0] dq_in
);
  import edoc_pkg::*;

  // Complete controller state, registered as one unit
  typedef struct packed {
    edoc_state_t st;
    logic [12:0] cnt;
    logic [8:0] ref_tmr;
    logic [2:0] ref_owed;
    logic [3:0] init_cnt;
    logic [11:0] pcnt;
    logic [10:0] sr_rows;
    logic [1:0] sr_phase;
    edoc_req_t cur;
    edoc_pins_t p;
    logic [15:0] sync1;
    logic [15:0] sync2;
    logic rsp;
    logic [15:0] rd;
  } edoc_regs_t;

  edoc_regs_t s; // Current state
  edoc_regs_t next_s; // Value for the next edge
  logic ref_tick; // Refresh interval elapsed
  logic ref_take; // A counted refresh starts now
  logic init_done; // Power-up sequence complete
  logic page_hit; // Next request may reuse the open row
  logic [1:0] be; // Effective byte enables
  logic [12:0] col_hold; // Column strobe low time of this access

  assign init_done = (s.init_cnt == 4'(`EDOC_INIT_CYCLES));
  // Page reuse needs same row and same direction, no refresh owed
  assign page_hit = req_valid && s.ref_owed == 3'h0 && sr_req == 1'b0 &&
    req.write == s.cur.write &&
    req.addr[`EDOC_ROW_MSB:`EDOC_ROW_LSB] ==
      s.cur.addr[`EDOC_ROW_MSB:`EDOC_ROW_LSB] &&
    s.pcnt < 12'(`EDOC_PAGE_CYC - `EDOC_PAGE_MARGIN); // see (RL13) (RL14)
  // Requests wait while refresh is owed or self refresh is wanted
  assign req_ready = (s.st == EDOC_IDLE && init_done &&
    s.ref_owed == 3'h0 && !sr_req) || (s.st == EDOC_CP && page_hit);
  // A zero mask would start no strobe, so treat it as a word access
  assign be = (s.cur.byte_en == 2'h0) ? 2'h3 : s.cur.byte_en; // see (RL21)
  assign col_hold = s.cur.write ? 13'(`EDOC_WR_CAS_CYC) :
    13'(`EDOC_RD_CAS_CYC);
  assign ref_tick = (s.ref_tmr == 9'(`EDOC_REF_INT_CYC - 1));
  assign ref_take = (s.st == EDOC_IDLE) && init_done &&
    (s.ref_owed != 3'h0) && (s.sr_phase == 2'h0);

  // Next-state logic for strobes, counters and refresh scheduling
  always_comb begin
    next_s = s;
    next_s.rsp = 1'b0;
    // Pin data passes two flops before any use
    next_s.sync1 = dq_in;
    next_s.sync2 = s.sync1;
    // Refresh interval, restarted after self refresh; a tick and a take in one cycle cancel out unless seven are owed
    next_s.ref_tmr = ref_tick ? 9'h0 : s.ref_tmr + 9'h1; // see (RL27)
    if (ref_tick && s.ref_owed != 3'h7) begin
      next_s.ref_owed = s.ref_owed + 3'h1 - {2'h0, ref_take}; // see (RL2)
    end else begin
      // Saturated or no tick: a take still pays one refresh off
      next_s.ref_owed = s.ref_owed - {2'h0, ref_take};
    end
    // Row-low time of an open page; self refresh opens no page
    next_s.pcnt = (s.p.ras_n || s.st == EDOC_SELF) ? 12'h0 :
      s.pcnt + 12'h1; // see (RL13)
    case (s.st)
      EDOC_POWERUP: begin
        // Quiet pause after power-up, then initial refreshes
        next_s.cnt = s.cnt + 13'h1;
        next_s.ref_owed = 3'h0;
        if (s.cnt == 13'(POWERUP_CYC - 1)) begin // see (RL1)
          next_s.st = EDOC_REF_CAS;
        end
      end
      EDOC_IDLE: begin
        if (!init_done || s.ref_owed != 3'h0) begin
          // Refresh first so no row misses its deadline
          next_s.st = EDOC_REF_CAS; // see (RL2)
        end else if (sr_req && s.sr_rows == 11'(`EDOC_REF_ROWS)) begin
          // Refresh once more just before entering self refresh
          next_s.sr_phase = 2'h1; // see (RL16) (RL18)
          next_s.st = EDOC_REF_CAS;
        end else if (req_valid && !sr_req) begin
          // Same refusal as req_ready: nothing taken while it is low
          next_s.cur = req;
          next_s.p.addr = req.addr[`EDOC_ROW_MSB:`EDOC_ROW_LSB];
          next_s.st = EDOC_ROW;
        end
      end
      EDOC_ROW: begin
        // Row address has settled; drop the row strobe
        next_s.p.ras_n = 1'b0;
        next_s.st = EDOC_COLA;
      end
      EDOC_COLA: begin
        // Column address, and write enable ahead of the column strobe
        next_s.p.addr = s.cur.addr[`EDOC_COL_MSB:`EDOC_COL_LSB];
        next_s.p.we_n = !s.cur.write; // see (RL3) (RL4) (RL8)
        // Output enable stays off while we drive data
        next_s.p.oe_n = s.cur.write; // see (RL6)
        next_s.p.dq_out = s.cur.wdata;
        next_s.p.dq_oe_n = !s.cur.write;
        next_s.st = EDOC_CASL;
      end
      EDOC_CASL: begin
        // Selected strobes fall on one edge, never skewed
        next_s.p.upper_col_strobe_n = !be[1]; // see (RL7) (RL20)
        next_s.p.lower_col_strobe_n = !be[0]; // see (RL19) (RL21)
        next_s.cnt = 13'h1;
        next_s.st = EDOC_COL;
      end
      EDOC_COL: begin
        next_s.cnt = s.cnt + 13'h1;
        if (s.cnt == col_hold) begin
          // Both strobes rise together; read data taken now
          next_s.p.upper_col_strobe_n = 1'b1; // see (RL9)
          next_s.p.lower_col_strobe_n = 1'b1;
          if (!s.cur.write) begin
            // Outputs were held enabled through the access
            next_s.rd = s.sync2; // see (RL12) (RL23)
            next_s.rsp = 1'b1;
          end
          next_s.st = EDOC_CP;
        end
      end
      EDOC_CP: begin
        // Both strobes high here: the column precharge cycle
        next_s.p.we_n = 1'b1; // see (RL22) (RL10)
        next_s.p.oe_n = 1'b1;
        next_s.p.dq_oe_n = 1'b1;
        if (page_hit) begin
          // Stay in the open row for the next column
          next_s.cur = req; // see (RL14)
          next_s.st = EDOC_COLA;
        end else begin
          next_s.p.ras_n = 1'b1;
          next_s.cnt = 13'h1;
          next_s.st = EDOC_PRE;
        end
      end
      EDOC_PRE: begin
        // Row precharge before the next row opens
        next_s.cnt = s.cnt + 13'h1;
        if (s.cnt >= 13'(`EDOC_RP_CYC)) begin // see (RL26)
          next_s.st = EDOC_IDLE;
        end
      end
      EDOC_REF_CAS: begin
        // Column strobes low before row strobe: internal refresh
        next_s.p.upper_col_strobe_n = 1'b0; // see (RL25)
        next_s.p.lower_col_strobe_n = 1'b0;
        next_s.p.we_n = 1'b1;
        next_s.p.oe_n = 1'b1;
        next_s.st = EDOC_REF_RAS;
      end
      EDOC_REF_RAS: begin
        next_s.p.ras_n = 1'b0;
        next_s.cnt = 13'h1;
        if (!s.p.ras_n) begin
          next_s.cnt = s.cnt + 13'h1;
          if (s.cnt >= 13'(`EDOC_RAS_CYC) && s.sr_phase == 2'h2) begin
            // Keep strobes low: the device enters self refresh
            next_s.sr_phase = 2'h0;
            next_s.cnt = 13'h0;
            next_s.ref_owed = 3'h0;
            next_s.st = EDOC_SELF;
          end else if (s.cnt >= 13'(`EDOC_RAS_CYC)) begin // see (RL26)
            next_s.p.ras_n = 1'b1;
            next_s.p.upper_col_strobe_n = 1'b1;
            next_s.p.lower_col_strobe_n = 1'b1;
            next_s.cnt = 13'h1;
            next_s.st = EDOC_REF_PRE;
          end
        end
      end
      EDOC_REF_PRE: begin
        next_s.cnt = s.cnt + 13'h1;
        if (s.cnt >= 13'(`EDOC_RP_CYC)) begin
          if (!init_done) begin
            next_s.init_cnt = s.init_cnt + 4'h1; // see (RL1)
          end
          if (s.sr_rows != 11'(`EDOC_REF_ROWS)) begin
            next_s.sr_rows = s.sr_rows + 11'h1; // see (RL17) (RL18)
          end
          if (s.sr_phase == 2'h1) begin
            next_s.sr_phase = 2'h2;
            next_s.st = EDOC_REF_CAS;
          end else if (!init_done && s.init_cnt != 4'(`EDOC_INIT_CYCLES - 1))
          begin
            next_s.st = EDOC_REF_CAS;
          end else begin
            next_s.st = EDOC_IDLE;
          end
        end
      end
      EDOC_SELF: begin
        // Hold at least the full self-refresh low time
        if (s.cnt != 13'(`EDOC_SELF_CYC)) begin
          next_s.cnt = s.cnt + 13'h1; // see (RL15)
        end else if (!sr_req) begin
          next_s.p.ras_n = 1'b1;
          next_s.p.upper_col_strobe_n = 1'b1;
          next_s.p.lower_col_strobe_n = 1'b1;
          next_s.cnt = 13'h1;
          next_s.st = EDOC_SELF_PRE;
        end
      end
      EDOC_SELF_PRE: begin
        // Longer precharge after self refresh, then refresh at once
        next_s.cnt = s.cnt + 13'h1;
        next_s.ref_owed = 3'h0;
        next_s.ref_tmr = 9'h0;
        if (s.cnt >= 13'(`EDOC_RPS_CYC)) begin // see (RL15)
          next_s.sr_rows = 11'h0; // see (RL18)
          next_s.st = EDOC_REF_CAS; // see (RL16)
        end
      end
      default: begin
        next_s.st = EDOC_IDLE;
      end
    endcase
  end

  // State register; all strobes inactive and data bus released at reset
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s <= '0;
      s.st <= EDOC_POWERUP;
      s.sr_rows <= 11'(`EDOC_REF_ROWS);
      s.p.ras_n <= 1'b1;
      s.p.upper_col_strobe_n <= 1'b1;
      s.p.lower_col_strobe_n <= 1'b1;
      s.p.we_n <= 1'b1;
      s.p.oe_n <= 1'b1;
      s.p.dq_oe_n <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign pins = s.p;
  assign rsp_valid = s.rsp;
  assign rdata = s.rd;
  assign sr_active = (s.st == EDOC_SELF);

  // Cycles since the last column-before-row refresh, for checking only
  logic [12:0] since_ref;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      since_ref <= 13'h0;
    end else if (s.st == EDOC_REF_RAS || !init_done || sr_active) begin
      since_ref <= 13'h0;
    end else if (since_ref != 13'h1fff) begin
      since_ref <= since_ref + 13'h1;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  sequence s_strobes_low;
    !pins.upper_col_strobe_n && !pins.lower_col_strobe_n;
  endsequence
  sequence s_cbr_start;
    s_strobes_low ##1 (s_strobes_low and $fell(pins.ras_n));
  endsequence

  a_cas_together: assert property ( // see (RL7)
    ($fell(pins.upper_col_strobe_n) || $fell(pins.lower_col_strobe_n)) |->
      $past(pins.upper_col_strobe_n) && $past(pins.lower_col_strobe_n))
    else $error("column strobes fell on different edges");
  a_early_write: assert property ( // see (RL3)
    ($fell(pins.upper_col_strobe_n) || $fell(pins.lower_col_strobe_n)) &&
      !pins.we_n |-> $past(!pins.we_n))
    else $error("write enable did not lead the column strobe");
  a_oe_off_drive: assert property ( // see (RL6)
    !pins.dq_oe_n |-> pins.oe_n && $past(pins.oe_n))
    else $error("data driven while output enable active");
  a_ras_min_low: assert property ( // see (RL26)
    $fell(pins.ras_n) |-> !pins.ras_n [*2])
    else $error("row strobe low shorter than minimum");
  a_cbr_sequence: assert property ( // see (RL25)
    s_cbr_start |-> ##1 !pins.ras_n ##1 pins.we_n)
    else $error("refresh sequence broken");
  a_self_exit_pre: assert property ( // see (RL15)
    $rose(pins.ras_n) && $past(sr_active) |-> pins.ras_n [*3])
    else $error("self refresh precharge too short");
  a_page_limit: assert property ( // see (RL13)
    !sr_active |-> s.pcnt <= 12'(`EDOC_PAGE_CYC))
    else $error("row held low beyond page limit");
  a_refresh_due: assert property ( // see (RL2)
    since_ref < 13'(`EDOC_REF_INT_CYC + 64))
    else $error("refresh interval exceeded");
  a_init_before: assert property ( // see (RL1)
    $fell(pins.ras_n) && pins.upper_col_strobe_n &&
      pins.lower_col_strobe_n |-> init_done)
    else $error("access before initial refreshes done");
  a_read_answer: assert property ( // see (RL12)
    $fell(pins.upper_col_strobe_n && pins.lower_col_strobe_n) && pins.we_n
      && !pins.oe_n |-> ##3 rsp_valid)
    else $error("read answer not on time");
endmodule

`default_nettype wire

/* edoc_defines.svh */
// Timing and sizing constants for the EDO DRAM strobe controller.
// Assumes a 25 MHz controller clock; times are kept in their own units.
`ifndef EDOC_DEFINES_SVH
`define EDOC_DEFINES_SVH

`define EDOC_CLK_NS 40
`define EDOC_CLK_MHZ 25
// Least times round up, longest times round down
`define EDOC_CEIL(ns) (((ns) + `EDOC_CLK_NS - 1) / `EDOC_CLK_NS)
`define EDOC_FLOOR(ns) ((ns) / `EDOC_CLK_NS)

`define EDOC_T_POWERUP_US 200
`define EDOC_POWERUP_CYC (`EDOC_T_POWERUP_US * `EDOC_CLK_MHZ)
`define EDOC_INIT_CYCLES 8
`define EDOC_REF_ROWS 1024
`define EDOC_T_REF_INT_NS 15600
`define EDOC_REF_INT_CYC `EDOC_FLOOR(`EDOC_T_REF_INT_NS)
`define EDOC_T_RAS_NS 60
`define EDOC_RAS_CYC `EDOC_CEIL(`EDOC_T_RAS_NS)
`define EDOC_T_RP_NS 40
`define EDOC_RP_CYC `EDOC_CEIL(`EDOC_T_RP_NS)
`define EDOC_SELF_REFRESH_PRECHARGE_TIME_NS 110
`define EDOC_RPS_CYC `EDOC_CEIL(`EDOC_SELF_REFRESH_PRECHARGE_TIME_NS)
`define EDOC_T_SELF_MIN_NS 100000
`define EDOC_SELF_CYC `EDOC_CEIL(`EDOC_T_SELF_MIN_NS)
`define EDOC_T_PAGE_MAX_NS 100000
`define EDOC_PAGE_CYC `EDOC_FLOOR(`EDOC_T_PAGE_MAX_NS)
// Margin so a page is closed before its row-low limit can be reached
`define EDOC_PAGE_MARGIN 16
`define EDOC_RD_CAS_CYC 3
`define EDOC_WR_CAS_CYC 1

// Field positions of the 20-bit word address
`define EDOC_ROW_MSB 19
`define EDOC_ROW_LSB 10
`define EDOC_COL_MSB 9
`define EDOC_COL_LSB 0

`endif

/* edoc_pkg.sv */
// Types shared by the EDO DRAM strobe controller and its users.
// Assumes edoc_defines.svh holds all numeric constants.
package edoc_pkg;
  // User request: 20-bit word address, byte enables, write data
  typedef struct packed {
    logic write;
    logic [1:0] byte_en;
    logic [19:0] addr;
    logic [15:0] wdata;
  } edoc_req_t;

  // Pins driven towards the memory; dq_oe_n low while driving data
  typedef struct packed {
    logic ras_n;
    logic upper_col_strobe_n;
    logic lower_col_strobe_n;
    logic we_n;
    logic oe_n;
    logic [9:0] addr;
    logic [15:0] dq_out;
    logic dq_oe_n;
  } edoc_pins_t;

  typedef enum logic [3:0] {
    EDOC_POWERUP, EDOC_IDLE, EDOC_ROW, EDOC_COLA, EDOC_CASL, EDOC_COL,
    EDOC_CP, EDOC_PRE, EDOC_REF_CAS, EDOC_REF_RAS, EDOC_REF_PRE,
    EDOC_SELF, EDOC_SELF_PRE
  } edoc_state_t;
endpackage

/* edoc_mem_model.sv */
// Behavioural model of the 1M x 16 EDO memory behind the controller.
// Assumes pins change just after clk rises; it samples them 1 ns later.
`timescale 1ns/100ps
`default_nettype none
module edoc_mem_model import edoc_pkg::*; (
  // Pacing clock
  input wire logic clk,
  // Memory pins
  input wire edoc_pkg::edoc_pins_t pins,
  output logic [15:0] dq_in
);
  logic [15:0] mem [int]; // Sparse cells, unwritten ones read 0
  edoc_pins_t p; // Pins at the previous edge
  logic acc, rd, uf, lf; // Row open, read cycle, strobe falls
  logic [9:0] row, col;
  logic [15:0] w, d;
  initial begin
    dq_in = 16'h0000;
    p = '1;
    acc = 0;
    rd = 0;
    row = '0;
    col = '0;
  end
  function automatic logic [15:0] peek(int a);
    return mem.exists(a) ? mem[a] : 16'h0000;
  endfunction
  // Strobe decode, write capture and read drive
  always @(posedge clk) begin
    #1;
    uf = p.upper_col_strobe_n && !pins.upper_col_strobe_n;
    lf = p.lower_col_strobe_n && !pins.lower_col_strobe_n;
    if (pins.ras_n) acc = 0;
    // Row fall with a strobe already low is a refresh, not an access
    if (p.ras_n && !pins.ras_n) begin
      acc = p.upper_col_strobe_n && p.lower_col_strobe_n;
      row = pins.addr;
      rd = 0;
    end
    // Cycle type set by the first strobe fall of either byte
    if (acc && (uf || lf) && p.upper_col_strobe_n && p.lower_col_strobe_n)
    begin
      col = pins.addr;
      rd = pins.we_n;
    end
    // Late write enable: read data undefined, so stop driving it
    if (rd && !pins.we_n) rd = 0;
    // Early write: each lane latched at its own strobe fall
    if (acc && !pins.we_n && (uf || lf)) begin
      w = peek({row, col});
      d = pins.dq_oe_n ? ~w : pins.dq_out; // Undriven bus stores noise
      if (uf) w[15:8] = d[15:8];
      if (lf) w[7:0] = d[7:0];
      mem[{row, col}] = w;
    end
    // Drive until the later of row and column rise, else noise
    if (rd && !pins.oe_n && (!pins.ras_n || !pins.upper_col_strobe_n ||
        !pins.lower_col_strobe_n)) dq_in = peek({row, col});
    else dq_in = ~dq_in;
    p = pins;
  end
endmodule
`default_nettype wire

/* tb_edoc_ctrl.sv */
// Self-checking bench for the EDO strobe controller with a memory model.
// Assumes a 25 MHz clock and a shortened power-up pause.
`timescale 1ns/100ps
`default_nettype none
module tb_edoc_ctrl;
  import edoc_pkg::*;
  localparam int PU = 20; // Shortened power-up pause
  logic clk, arst_n, req_valid, req_ready, rsp_valid, sr_req, sr_active;
  edoc_req_t req;
  edoc_pins_t pins, p;
  logic [15:0] rdata, dq_in;
  int n_mismatch, tests_run, cyc, lo, hi, cbr_n, sx, last_cbr, prev_cbr;
  int sx_exit, re, rm;
  logic col_before_row_refresh, was_self, pend, first, rec_we, uf, lf;
  int ref_mem [int]; // Reference memory
  int exp_q [$], msk_q [$]; // Expected reads and lane masks
  edoc_ctrl #(.POWERUP_CYC(PU)) DUT (.clk(clk), .arst_n(arst_n),
    .req_valid(req_valid), .req_ready(req_ready), .req(req),
    .rsp_valid(rsp_valid), .rdata(rdata), .sr_req(sr_req),
    .sr_active(sr_active), .pins(pins), .dq_in(dq_in));
  edoc_mem_model MEM (.clk(clk), .pins(pins), .dq_in(dq_in));
  initial begin
    clk = 0;
    forever #20 clk = ~clk;
  end
  task automatic fail(string s);
    n_mismatch++;
    $display("[ERR] %0t %s", $time, s);
  endtask
  task automatic check(logic c, string s);
    tests_run++;
    if (c !== 1'b1) fail(s);
  endtask
  task automatic summarize();
    if (n_mismatch == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // One request; valid stays up so back-to-back calls need no gap
  task automatic put(edoc_req_t r);
    int k, m, a;
    req <= r;
    req_valid <= 1'b1;
    k = 0;
    do begin @(negedge clk); k++; end while (req_ready !== 1'b1 && k < 4000);
    check(k < 4000, "request never taken");
    @(posedge clk);
    a = int'(r.addr);
    m = (r.byte_en == 2'b00) ? 'hffff :
      {{8{r.byte_en[1]}}, {8{r.byte_en[0]}}};
    if (!ref_mem.exists(a)) ref_mem[a] = 0;
    if (r.write) ref_mem[a] = (ref_mem[a] & ~m) | (r.wdata & m);
    else begin
      exp_q.push_back(ref_mem[a]);
      msk_q.push_back(m);
    end
  endtask
  // Random mix in a small pool so page hits and rewrites are common
  task automatic traffic(int n);
    edoc_req_t r;
    for (int i = 0; i < n; i++) begin
      r.write = 1'($urandom_range(0, 1));
      r.byte_en = 2'($urandom_range(0, 3));
      r.addr = {8'h00, 2'($urandom_range(0, 3)), 7'h00,
        3'($urandom_range(0, 7))};
      r.wdata = 16'($urandom);
      put(r);
    end
    req_valid <= 1'b0;
  endtask
  task automatic wait_sr(logic v, int lim);
    int k;
    k = 0;
    while (sr_active !== v && k < lim) begin @(negedge clk); k++; end
    check(sr_active === v, "self refresh state not reached");
    @(posedge clk);
  endtask
  // Pin monitor, sampled midway between edges where pins are settled
  always @(negedge clk) begin
    if (!arst_n) begin
      cyc = 0; lo = 0; hi = 0; cbr_n = 0; sx = 1024; pend = 0; col_before_row_refresh = 0;
      was_self = 0; first = 1; rec_we = 1; last_cbr = 0; prev_cbr = 0;
      p = pins;
    end else begin
      cyc++;
      if (p.ras_n && !pins.ras_n) begin
        col_before_row_refresh = !(pins.upper_col_strobe_n && pins.lower_col_strobe_n);
        check(cyc > PU, "row strobe in power-up pause");
        check(hi >= (was_self ? 3 : 1), "precharge short");
        if (col_before_row_refresh) begin
          if (pend)
            check(cyc - sx_exit <= 390, "no refresh after self");
          else if (cbr_n >= 8)
            check(cyc - last_cbr <= 820, "refresh gap too long");
          pend = 0; was_self = 0; prev_cbr = last_cbr; last_cbr = cyc;
          cbr_n++; sx++;
        end else check(cbr_n >= 8, "access before eight refreshes");
        first = 1; lo = 0;
      end
      if (!p.ras_n && pins.ras_n) begin
        check(lo >= 2, "row low too short");
        if (col_before_row_refresh && lo >= 250) begin
          check(lo >= 2500, "self refresh low in transition band");
          check(sx > 1024, "self refresh without full refresh");
          check(last_cbr - prev_cbr <= 390,
            "no refresh before self");
          sx = 0; was_self = 1; pend = 1; sx_exit = cyc;
        end else if (!col_before_row_refresh) check(lo <= 2500, "row open too long");
        hi = 0;
      end
      if (!pins.ras_n && !col_before_row_refresh) begin
        uf = p.upper_col_strobe_n && !pins.upper_col_strobe_n;
        lf = p.lower_col_strobe_n && !pins.lower_col_strobe_n;
        check(!(uf && !p.lower_col_strobe_n) && !(lf && !p.upper_col_strobe_n),
          "byte strobes staggered");
        if (uf || lf) begin
          if (first) rec_we = pins.we_n;
          check(pins.we_n === rec_we, "mixed page");
          first = 0;
        end
        if (!(p.upper_col_strobe_n && p.lower_col_strobe_n) &&
            !(pins.upper_col_strobe_n && pins.lower_col_strobe_n))
          check(pins.we_n === p.we_n, "write enable moved");
      end
      check(pins.dq_oe_n || pins.oe_n, "bus contention");
      if (pins.ras_n) hi++;
      else lo++;
      p = pins;
    end
  end
  // Read answers against the reference, selected lanes only
  always @(negedge clk) begin
    if (arst_n === 1'b1 && rsp_valid === 1'b1) begin
      if (exp_q.size() == 0) fail("unexpected read answer");
      else begin
        re = exp_q.pop_front();
        rm = msk_q.pop_front();
        check((rdata & rm[15:0]) === (re[15:0] & rm[15:0]),
          "read data mismatch");
      end
    end
  end
  initial begin
    arst_n = 0; req_valid = 0; req = '0; sr_req = 0;
    n_mismatch = 0; tests_run = 0;
    void'($urandom(18496));
    repeat (20) @(posedge clk);
    arst_n <= 1;
    traffic(300);
    sr_req <= 1;
    wait_sr(1'b1, 6000);
    repeat (2600) @(posedge clk);
    sr_req <= 0;
    wait_sr(1'b0, 200);
    sr_req <= 1;
    // Re-entry must wait for a full refresh of all rows
    for (int i = 0; i < 3000; i++) begin
      @(negedge clk);
      check(sr_active !== 1'b1, "self refresh re-entered early");
    end
    @(posedge clk);
    sr_req <= 0;
    traffic(100);
    repeat (20) @(posedge clk);
    check(exp_q.size() == 0, "reads left unanswered");
    summarize();
  end
  // Watchdog: the whole run needs about 9000 cycles
  initial begin
    repeat (60000) @(posedge clk);
    fail("watchdog expired");
    summarize();
  end
endmodule
`default_nettype wire
